// ===== hdl/rsn_pkg.sv
package rsn_pkg;

    // Block geometry
    localparam int BLOCK_BYTES = 512;
    localparam int CHECK_BYTES = 9;
    localparam int CODE_LEN = BLOCK_BYTES + CHECK_BYTES;
    localparam logic [9:0] IDX_DATA_LAST = 10'(BLOCK_BYTES - 1);
    localparam logic [9:0] IDX_BLOCK_END = 10'(BLOCK_BYTES);
    localparam logic [9:0] IDX_CHECK_LAST = 10'(CHECK_BYTES - 1);
    localparam logic [9:0] IDX_CODE_LAST = 10'(CODE_LEN - 1);

    // Field polynomial x^8+x^4+x^3+x^2+1 and fixed exponents
    localparam logic [8:0] GF_POLY = 9'h11D;
    localparam int ALPHA_INV_EXP = 254;
    localparam int ALPHA_TOP_EXP = CODE_LEN - 1;

    // Register byte offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h68;
    localparam logic [7:0] ADDR_EXP_LOW = 8'h6C;
    localparam logic [7:0] ADDR_EXP_MID = 8'h70;
    localparam logic [7:0] ADDR_EXP_TOP = 8'h74;
    localparam logic [7:0] ADDR_CMP_LOW = 8'h78;
    localparam logic [7:0] ADDR_CMP_MID = 8'h7C;
    localparam logic [7:0] ADDR_CMP_TOP = 8'h80;
    localparam logic [7:0] ADDR_OUTCOME = 8'h84;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h88;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h8C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h90;

    // Control bits
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_CORRECT_BIT = 1;
    localparam int CTL_PRECOMP_BIT = 2;

    // Interrupt bits
    localparam int IRQ_WIDTH = 3;
    localparam int IRQ_WRITE_PAR = 0;
    localparam int IRQ_READ_CHECK = 1;
    localparam int IRQ_RELOAD = 2;

    typedef enum logic [1:0] {
        OUTCOME_NONE = 2'h0,
        OUTCOME_CORRECTABLE = 2'h1,
        OUTCOME_UNCORRECTABLE = 2'h2
    } rsn_outcome_e;

    // GF(256) product
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ x;
            x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY[7:0]) : {x[6:0], 1'b0};
        end
        return p;
    endfunction : gf_mul

    // Power of the primitive element
    function automatic logic [7:0] gf_pow(input int e);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < e; i++)
            r = gf_mul(r, 8'h02);
        return r;
    endfunction : gf_pow

    // Generator coefficient, roots alpha^0..alpha^8
    function automatic logic [7:0] gen_coef(input int idx);
        logic [7:0] g [0:CHECK_BYTES];
        logic [7:0] root;
        for (int j = 0; j <= CHECK_BYTES; j++)
            g[j] = 8'h00;
        g[0] = 8'h01;
        for (int k = 0; k < CHECK_BYTES; k++)
        begin
            root = gf_pow(k);
            for (int j = CHECK_BYTES; j > 0; j--)
                g[j] = g[j-1] ^ gf_mul(g[j], root);
            g[0] = gf_mul(g[0], root);
        end
        return g[idx];
    endfunction : gen_coef

endpackage : rsn_pkg

// ===== hdl/rsn_encoder.sv
`timescale 1ns/1ps
module rsn_encoder (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Byte stream
    input wire logic clear,
    input wire logic inValid,
    input wire logic [7:0] inData,
    // Remainder, x^8 term in the top byte
    output logic [71:0] parity
);

    logic [7:0] check [0:8];
    logic [7:0] next_check [0:8];

    // Division remainder by the generator; clear restarts on the first byte
    always_comb
    begin
        logic [7:0] base [0:8];
        logic [7:0] fb;
        for (int k = 0; k < rsn_pkg::CHECK_BYTES; k++)
            base[k] = clear ? 8'h00 : check[k];
        fb = inData ^ base[rsn_pkg::CHECK_BYTES-1];
        for (int k = 0; k < rsn_pkg::CHECK_BYTES; k++)
        begin
            if (!inValid)
                next_check[k] = check[k];
            else if (k == 0)
                next_check[k] = rsn_pkg::gf_mul(fb, rsn_pkg::gen_coef(0));
            else
                next_check[k] = base[k-1] ^ rsn_pkg::gf_mul(fb, rsn_pkg::gen_coef(k));
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            for (int k = 0; k < rsn_pkg::CHECK_BYTES; k++)
                check[k] <= 8'h00;
        else
            check <= next_check;
    end

    genvar gk;
    generate
        for (gk = 0; gk < rsn_pkg::CHECK_BYTES; gk++)
        begin : g_out
            assign parity[8*gk +: 8] = check[gk];
        end
    endgenerate

endmodule : rsn_encoder

// ===== hdl/rsn_syndrome.sv
`timescale 1ns/1ps
module rsn_syndrome (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Codeword stream, highest degree first
    input wire logic clear,
    input wire logic inValid,
    input wire logic [7:0] inData,
    // Syndrome k in bits 8k+7:8k
    output logic [71:0] syndromes
);

    logic [7:0] acc [0:8];
    logic [7:0] next_acc [0:8];

    // Horner evaluation at alpha^k
    always_comb
    begin
        logic [7:0] base;
        base = 8'h00;
        for (int k = 0; k < rsn_pkg::CHECK_BYTES; k++)
        begin
            base = clear ? 8'h00 : acc[k];
            next_acc[k] = inValid ? (rsn_pkg::gf_mul(base, rsn_pkg::gf_pow(k)) ^ inData)
                                  : acc[k];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            for (int k = 0; k < rsn_pkg::CHECK_BYTES; k++)
                acc[k] <= 8'h00;
        else
            acc <= next_acc;
    end

    genvar gk;
    generate
        for (gk = 0; gk < rsn_pkg::CHECK_BYTES; gk++)
        begin : g_out
            assign syndromes[8*gk +: 8] = acc[gk];
        end
    endgenerate

endmodule : rsn_syndrome

// ===== hdl/rsn_ecc_ctrl.sv
// Summary of operation
// - Precompute kick encodes block, nothing to flash
// - Kick pops 512 transmit bytes, self-clears
// - Precomputed check bytes readable afterwards
// - Correction kick reloads corrected block inward
// - Enable bit gates checking and generation
// - Expected check split over three registers
// - Written-block check bytes in three registers
// - Two-bit read outcome after block check
`timescale 1ns/1ps
module rsn_ecc_ctrl #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq,
    // Transmit FIFO drain for precompute
    input wire logic [7:0] txFifoData,
    input wire logic txFifoValid,
    output logic txFifoReady,
    // Bytes going to flash on a block write
    input wire logic [7:0] flashWrData,
    input wire logic flashWrValid,
    // Bytes coming from flash on a block read
    input wire logic [7:0] flashRdData,
    input wire logic flashRdValid,
    // Input FIFO fill for corrected block
    output logic [7:0] inFifoData,
    output logic inFifoValid,
    input wire logic inFifoReady
);

    typedef enum {ST_IDLE, ST_PRECOMP, ST_PARFEED, ST_SEARCH, ST_RELOAD} rsn_state_e;

    // Package constants, declared ahead of every use
    localparam int IRQ_W = rsn_pkg::IRQ_WIDTH;
    localparam logic [9:0] IDX_DATA_LAST = rsn_pkg::IDX_DATA_LAST;
    localparam logic [9:0] IDX_BLOCK_END = rsn_pkg::IDX_BLOCK_END;
    localparam logic [9:0] IDX_CHECK_LAST = rsn_pkg::IDX_CHECK_LAST;
    localparam logic [9:0] IDX_CODE_LAST = rsn_pkg::IDX_CODE_LAST;
    localparam logic [7:0] ADDR_CONTROL = rsn_pkg::ADDR_CONTROL;
    localparam logic [7:0] ADDR_EXP_LOW = rsn_pkg::ADDR_EXP_LOW;
    localparam logic [7:0] ADDR_EXP_MID = rsn_pkg::ADDR_EXP_MID;
    localparam logic [7:0] ADDR_EXP_TOP = rsn_pkg::ADDR_EXP_TOP;
    localparam logic [7:0] ADDR_CMP_LOW = rsn_pkg::ADDR_CMP_LOW;
    localparam logic [7:0] ADDR_CMP_MID = rsn_pkg::ADDR_CMP_MID;
    localparam logic [7:0] ADDR_CMP_TOP = rsn_pkg::ADDR_CMP_TOP;
    localparam logic [7:0] ADDR_OUTCOME = rsn_pkg::ADDR_OUTCOME;
    localparam logic [7:0] ADDR_IRQ_STATUS = rsn_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] ADDR_IRQ_ENABLE = rsn_pkg::ADDR_IRQ_ENABLE;
    localparam logic [7:0] ADDR_IRQ_CLEAR = rsn_pkg::ADDR_IRQ_CLEAR;
    localparam logic [1:0] OUTCOME_NONE = rsn_pkg::OUTCOME_NONE;
    localparam logic [1:0] OUTCOME_CORRECTABLE = rsn_pkg::OUTCOME_CORRECTABLE;
    localparam logic [1:0] OUTCOME_UNCORRECTABLE = rsn_pkg::OUTCOME_UNCORRECTABLE;

    rsn_state_e state, next_state;
    logic [9:0] count, next_count;
    logic [9:0] wrCount, next_wrCount;
    logic [9:0] rdCount, next_rdCount;
    logic capture, next_capture;
    logic enable, next_enable;
    logic precompKick, next_precompKick;
    logic correctKick, next_correctKick;
    logic [71:0] expected, next_expected;
    logic [71:0] computed, next_computed;
    logic [1:0] outcome, next_outcome;
    logic [9:0] errPos, next_errPos;
    logic [7:0] errVal, next_errVal;
    logic found, next_found;
    logic [7:0] searchTerm, next_searchTerm;
    logic [IRQ_W-1:0] irqStatus, next_irqStatus;
    logic [IRQ_W-1:0] irqEnable, next_irqEnable;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic [7:0] outData, next_outData;
    logic outValid, next_outValid;
    logic [7:0] blockMem [0:rsn_pkg::BLOCK_BYTES-1];

    logic encClear, encValid;
    logic [7:0] encData;
    logic [71:0] encParity;
    logic synClear, synValid;
    logic [7:0] synData;
    logic [71:0] syn;
    logic memWrite;

    // Byte-lane merge for writable registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] val,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[8*b +: 8] = val[8*b +: 8];
        return r;
    endfunction : lane_merge

    // Syndrome byte k
    function automatic logic [7:0] syn_byte(input logic [71:0] s, input int k);
        return s[8*k +: 8];
    endfunction : syn_byte

    // Encoder takes the transmit FIFO on a precompute, else the flash write stream
    assign txFifoReady = (state == ST_PRECOMP);
    assign encValid = (state == ST_PRECOMP) ? txFifoValid
                    : (state == ST_IDLE) && enable && flashWrValid;
    assign encData = (state == ST_PRECOMP) ? txFifoData : flashWrData;
    assign encClear = (state == ST_PRECOMP) ? (count == 10'h000) : (wrCount == 10'h000);

    // Syndromes see the read block, then the expected check bytes, top byte first
    assign memWrite = (state == ST_IDLE) && enable && flashRdValid;
    assign synValid = memWrite || (state == ST_PARFEED);
    assign synData = (state == ST_PARFEED)
                   ? expected[8*(rsn_pkg::CHECK_BYTES-1-int'(count)) +: 8]
                   : flashRdData;
    assign synClear = (state == ST_IDLE) && (rdCount == 10'h000);

    rsn_encoder u_encoder (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clear(encClear),
        .inValid(encValid),
        .inData(encData),
        .parity(encParity)
    );

    rsn_syndrome u_syndrome (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clear(synClear),
        .inValid(synValid),
        .inData(synData),
        .syndromes(syn)
    );

    // Read block copy, kept for the corrected reload
    always_ff @(posedge ref_clk)
    begin
        if (memWrite)
            blockMem[rdCount[8:0]] <= flashRdData;
    end

    // Engine, register file and bus answer
    always_comb
    begin
        logic access;
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] clr;
        logic [7:0] curTerm;
        logic consistent;
        logic allZero;
        logic match;
        access = wb_cyc_i && wb_stb_i && !ack;
        events = '0;
        clr = '0;
        curTerm = (count == 10'h000)
                ? rsn_pkg::gf_mul(syn_byte(syn, 0), rsn_pkg::gf_pow(rsn_pkg::ALPHA_TOP_EXP))
                : searchTerm;
        match = (curTerm == syn_byte(syn, 1));
        allZero = (syn == 72'h0);
        consistent = (syn_byte(syn, 0) != 8'h00);
        for (int k = 1; k < rsn_pkg::CHECK_BYTES - 1; k++)
            if (rsn_pkg::gf_mul(syn_byte(syn, k+1), syn_byte(syn, 0))
                != rsn_pkg::gf_mul(syn_byte(syn, k), syn_byte(syn, 1)))
                consistent = 1'b0;
        next_state = state;
        next_count = count;
        next_wrCount = wrCount;
        next_rdCount = rdCount;
        next_capture = 1'b0;
        next_enable = enable;
        next_precompKick = precompKick;
        next_correctKick = correctKick;
        next_expected = expected;
        next_computed = computed;
        next_outcome = outcome;
        next_errPos = errPos;
        next_errVal = errVal;
        next_found = found;
        next_searchTerm = searchTerm;
        next_irqEnable = irqEnable;
        next_ack = access;
        next_rdata = 32'h0000_0000;
        next_outData = outData;
        next_outValid = outValid;

        // Parity settles one edge after the last byte
        if (capture)
        begin
            next_computed = encParity;
            events[rsn_pkg::IRQ_WRITE_PAR] = 1'b1;
        end

        unique case (state)
            ST_IDLE:
            begin
                if (enable && flashWrValid)
                    next_wrCount = (wrCount == IDX_DATA_LAST) ? 10'h000 : wrCount + 10'h001;
                if (enable && flashWrValid && wrCount == IDX_DATA_LAST)
                    next_capture = 1'b1;
                if (memWrite)
                begin
                    next_rdCount = (rdCount == IDX_DATA_LAST) ? 10'h000 : rdCount + 10'h001;
                    if (rdCount == IDX_DATA_LAST)
                    begin
                        next_state = ST_PARFEED;
                        next_count = 10'h000;
                    end
                end
                else if (precompKick)
                begin
                    next_precompKick = enable;
                    next_wrCount = 10'h000;
                    next_count = 10'h000;
                    if (enable)
                        next_state = ST_PRECOMP;
                end
                else if (correctKick)
                begin
                    next_count = 10'h000;
                    if (enable && outcome == OUTCOME_CORRECTABLE)
                        next_state = ST_RELOAD;
                    else
                        next_correctKick = 1'b0;
                end
            end
            ST_PRECOMP:
            begin
                // Flash sees nothing from this pass
                if (txFifoValid)
                begin
                    next_count = count + 10'h001;
                    if (count == IDX_DATA_LAST)
                    begin
                        next_state = ST_IDLE;
                        next_precompKick = 1'b0;
                        next_capture = 1'b1;
                    end
                end
            end
            ST_PARFEED:
            begin
                next_count = count + 10'h001;
                if (count == IDX_CHECK_LAST)
                begin
                    next_state = ST_SEARCH;
                    next_count = 10'h000;
                    next_found = 1'b0;
                end
            end
            ST_SEARCH:
            begin
                // One location per cycle; single-byte errors only
                next_searchTerm = rsn_pkg::gf_mul(curTerm, rsn_pkg::gf_pow(rsn_pkg::ALPHA_INV_EXP));
                next_count = count + 10'h001;
                if (match && !found)
                begin
                    next_found = 1'b1;
                    next_errPos = count;
                end
                if (count == IDX_CODE_LAST)
                begin
                    next_state = ST_IDLE;
                    next_count = 10'h000;
                    next_errVal = syn_byte(syn, 0);
                    if (allZero)
                        next_outcome = OUTCOME_NONE;
                    else if (consistent && (found || match))
                        next_outcome = OUTCOME_CORRECTABLE;
                    else
                        next_outcome = OUTCOME_UNCORRECTABLE;
                    events[rsn_pkg::IRQ_READ_CHECK] = 1'b1;
                end
            end
            ST_RELOAD:
            begin
                // Next byte only once the input FIFO took the last one
                if (!outValid || inFifoReady)
                begin
                    if (count == IDX_BLOCK_END)
                    begin
                        next_outValid = 1'b0;
                        next_state = ST_IDLE;
                        next_correctKick = 1'b0;
                        next_count = 10'h000;
                        events[rsn_pkg::IRQ_RELOAD] = 1'b1;
                    end
                    else
                    begin
                        next_outData = blockMem[count[8:0]]
                                     ^ ((count == errPos) ? errVal : 8'h00);
                        next_outValid = 1'b1;
                        next_count = count + 10'h001;
                    end
                end
            end
        endcase

        // Register writes take effect in the cycle the request is taken
        if (access && wb_we_i)
        begin
            unique case (wb_adr_i[7:0])
                ADDR_CONTROL:
                    if (wb_sel_i[0])
                    begin
                        next_enable = wb_dat_i[rsn_pkg::CTL_ENABLE_BIT];
                        if (wb_dat_i[rsn_pkg::CTL_PRECOMP_BIT])
                            next_precompKick = 1'b1;
                        if (wb_dat_i[rsn_pkg::CTL_CORRECT_BIT])
                            next_correctKick = 1'b1;
                    end
                ADDR_EXP_LOW:
                    next_expected[31:0] = lane_merge(expected[31:0], wb_dat_i, wb_sel_i);
                ADDR_EXP_MID:
                    next_expected[63:32] = lane_merge(expected[63:32], wb_dat_i, wb_sel_i);
                ADDR_EXP_TOP:
                    if (wb_sel_i[0])
                        next_expected[71:64] = wb_dat_i[7:0];
                ADDR_IRQ_ENABLE:
                    if (wb_sel_i[0])
                        next_irqEnable = wb_dat_i[IRQ_W-1:0];
                ADDR_IRQ_CLEAR:
                    if (wb_sel_i[0])
                        clr = wb_dat_i[IRQ_W-1:0];
                default:
                    next_ack = access;
            endcase
        end

        // Read mux; unmapped and write-only offsets read zero
        if (access && !wb_we_i)
        begin
            unique case (wb_adr_i[7:0])
                ADDR_CONTROL:
                begin
                    next_rdata[rsn_pkg::CTL_ENABLE_BIT] = enable;
                    next_rdata[rsn_pkg::CTL_CORRECT_BIT] = correctKick;
                    next_rdata[rsn_pkg::CTL_PRECOMP_BIT] = precompKick;
                end
                ADDR_EXP_LOW: next_rdata = expected[31:0];
                ADDR_EXP_MID: next_rdata = expected[63:32];
                ADDR_EXP_TOP: next_rdata[7:0] = expected[71:64];
                ADDR_CMP_LOW: next_rdata = computed[31:0];
                ADDR_CMP_MID: next_rdata = computed[63:32];
                ADDR_CMP_TOP: next_rdata[7:0] = computed[71:64];
                ADDR_OUTCOME: next_rdata[1:0] = outcome;
                ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irqStatus;
                ADDR_IRQ_ENABLE: next_rdata[IRQ_W-1:0] = irqEnable;
                default: next_rdata = 32'h0000_0000;
            endcase
        end

        // New event wins over a clear in the same cycle
        next_irqStatus = (irqStatus & ~clr) | events;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            count <= 10'h000;
            wrCount <= 10'h000;
            rdCount <= 10'h000;
            capture <= 1'b0;
            enable <= 1'b0;
            precompKick <= 1'b0;
            correctKick <= 1'b0;
            expected <= 72'h0;
            computed <= 72'h0;
            outcome <= OUTCOME_NONE;
            errPos <= 10'h000;
            errVal <= 8'h00;
            found <= 1'b0;
            searchTerm <= 8'h00;
            irqStatus <= '0;
            irqEnable <= '0;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            outData <= 8'h00;
            outValid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            wrCount <= next_wrCount;
            rdCount <= next_rdCount;
            capture <= next_capture;
            enable <= next_enable;
            precompKick <= next_precompKick;
            correctKick <= next_correctKick;
            expected <= next_expected;
            computed <= next_computed;
            outcome <= next_outcome;
            errPos <= next_errPos;
            errVal <= next_errVal;
            found <= next_found;
            searchTerm <= next_searchTerm;
            irqStatus <= next_irqStatus;
            irqEnable <= next_irqEnable;
            ack <= next_ack;
            rdata <= next_rdata;
            outData <= next_outData;
            outValid <= next_outValid;
        end
    end

    // Outputs
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign irq = |(irqStatus & irqEnable);
    assign inFifoData = outData;
    assign inFifoValid = outValid;

endmodule : rsn_ecc_ctrl

// ===== sim/rsn_ecc_chk.sv
`timescale 1ns/1ps
module rsn_ecc_chk #(parameter int ADDR_W = 8) (
    // Bus and stream ports watched
    input wire logic ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic txFifoReady, inFifoValid, inFifoReady,
    input wire logic [7:0] inFifoData
);
    // Read answer in this cycle
    wire rd = wb_ack_o && !wb_we_i;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    idle_zero_a: assert property (!wb_ack_o |-> ~|wb_dat_o) else $error("data off ack");
    unmap_zero_a: assert property (rd && (wb_adr_i < 8'h68 || wb_adr_i > 8'h90) |-> ~|wb_dat_o)
        else $error("unmapped data");
    top_rsv_a: assert property (rd && (wb_adr_i == 8'h74 || wb_adr_i == 8'h80) |-> ~|wb_dat_o[31:8])
        else $error("top byte wide");
    out_rsv_a: assert property (rd && wb_adr_i == 8'h84 |-> ~|wb_dat_o[31:2] && wb_dat_o[1:0] != 2'h3)
        else $error("bad outcome");
    reload_hold_a: assert property (inFifoValid && !inFifoReady |=> inFifoValid && $stable(inFifoData))
        else $error("reload byte lost");
    path_excl_a: assert property (txFifoReady |-> !inFifoValid) else $error("both paths");
endmodule : rsn_ecc_chk
bind rsn_ecc_ctrl rsn_ecc_chk #(.ADDR_W(ADDR_W)) chk (.*);

// ===== sim/rsn_flash_mdl.sv
`timescale 1ns/1ps
module rsn_flash_mdl (
    // Source side of transmit FIFO and flash
    input wire logic ref_clk, ready,
    input wire logic [1:0] mode,
    input wire logic [7:0] blk [512],
    output logic [7:0] dat = 8'h00,
    output logic txV = 1'b0, rdV = 1'b0
);
    int i = 0;
    logic v;
    // Mode 1 feeds the transmit side, 2 streams a read with gaps, 3 writes flash
    always @(posedge ref_clk)
    begin
        i = (mode == 2'h0) ? 0 : i + int'(txV && (ready || mode == 2'h3) || rdV);
        v = i < 512 && mode != 2'h0 && (mode != 2'h2 || $urandom % 3 != 0);
        txV <= v && mode[0];
        rdV <= v && mode == 2'h2;
        dat <= v ? blk[i] : ~dat; // Idle bus never repeats a byte
    end
endmodule : rsn_flash_mdl

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, rdy = 1'b0;
    logic [7:0] adr = 8'h00, fd, inD, orig [512], blk [512];
    logic [31:0] dat = 32'h0, rdat, q, p [3];
    logic [1:0] mode = 2'h0;
    logic ack, irq, txR, txV, rdV, inV;
    int mismatches = 0, compares = 0, n, k;
    // 100 MHz
    always #5 ref_clk = ~ref_clk;
    rsn_ecc_ctrl uut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq(irq), .txFifoData(fd), .txFifoValid(txV), .txFifoReady(txR),
        .flashWrData(fd), .flashWrValid(txV), .flashRdData(fd), .flashRdValid(rdV),
        .inFifoData(inD), .inFifoValid(inV), .inFifoReady(rdy));
    rsn_flash_mdl nand_m (.ref_clk(ref_clk), .ready(txR), .mode(mode), .blk(blk),
        .dat(fd), .txV(txV), .rdV(rdV));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL %0t %h %h", $time, g, e);
        end
    endtask : chk
    // Single cycle, held until ack is seen
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask : wb
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rc
    task automatic wirq;
        for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge ref_clk);
        chk(32'(irq), 32'h1);
    endtask : wirq
    task automatic complete_run;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // Watchdog, far beyond the expected run
    initial
    begin
        #300000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        void'($urandom(31855));
        foreach (orig[j]) orig[j] = 8'($urandom);
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        for (k = 8'h64; k <= 8'h94; k += 4) rc(8'(k), 32'h0);
        // Expected check keeps its width, computed check ignores writes
        for (k = 0; k < 4; k++)
        begin
            p[0] = $urandom;
            wb(1'b1, 8'h6C + 8'(4 * k), p[0]);
            rc(8'h6C + 8'(4 * k), k == 3 ? 32'h0 : k == 2 ? p[0] & 32'hFF : p[0]);
        end
        wb(1'b1, 8'h8C, 32'h7);
        wb(1'b1, 8'h68, 32'h1);
        wb(1'b1, 8'h68, 32'h5);
        blk = orig;
        mode <= 2'h1;
        wirq;
        mode <= 2'h0;
        rc(8'h68, 32'h1);
        rc(8'h88, 32'h1);
        for (k = 0; k < 3; k++)
        begin
            wb(1'b0, 8'h78 + 8'(4 * k), 32'h0);
            p[k] = q;
        end
        wb(1'b1, 8'h90, 32'h7);
        // Same block written to flash must give the same check bytes
        mode <= 2'h3;
        wirq;
        mode <= 2'h0;
        for (k = 0; k < 3; k++) rc(8'h78 + 8'(4 * k), p[k]);
        wb(1'b1, 8'h90, 32'h7);
        // Clean block, one bad byte, two bad bytes
        for (int e = 0; e < 3; e++)
        begin
            blk = orig;
            for (k = 0; k < e; k++) blk[k * 97 + 5] ^= 8'h5A;
            for (k = 0; k < 3; k++) wb(1'b1, 8'h6C + 8'(4 * k), p[k]);
            mode <= 2'h2;
            wirq;
            mode <= 2'h0;
            rc(8'h84, 32'(e));
            rc(8'h88, 32'h2);
            wb(1'b1, 8'h8C, 32'h0);
            chk(32'(irq), 32'h0);
            wb(1'b1, 8'h8C, 32'h7);
            chk(32'(irq), 32'h1);
            wb(1'b1, 8'h90, 32'h7);
            chk(32'(irq), 32'h0);
            if (e == 1)
            begin
                wb(1'b1, 8'h68, 32'h3);
                for (n = 0; n < 512;)
                begin
                    @(posedge ref_clk);
                    if (inV === 1'b1 && rdy)
                    begin
                        chk(32'(inD), 32'(orig[n]));
                        n++;
                    end
                    rdy <= 1'($urandom);
                end
                wirq;
                rc(8'h88, 32'h4);
                wb(1'b1, 8'h90, 32'h7);
            end
        end
        // Kick while the codec is off does nothing
        wb(1'b1, 8'h68, 32'h4);
        mode <= 2'h1;
        repeat (4) @(posedge ref_clk);
        chk(32'(txR), 32'h0);
        rc(8'h68, 32'h0);
        complete_run();
    end
endmodule : tb_top
